// [wlc_warning_latch.sv]
// Warning latch, timed release and hardware alarm reporting for a servo drive.
// Assumes raw causes come from same-clock logic except encoder batt release (pin).
`timescale 1ns/1ps

module wlc_warning_latch #(
  parameter int unsigned CLEAR_CYCLES = wlc_pkg::CLEAR_CYCLES // Shorten in simulation
) (
  input  wire logic                          clk,                  // 125 MHz control clock
  input  wire logic                          reset_n,              // Sync reset, active low
  input  wire logic [wlc_pkg::NUM_WARN-1:0]  warn_cause,           // Raw warning causes
  input  wire logic [wlc_pkg::NUM_WARN-1:0]  warn_is_extended,     // 1 marks an extended warning
  input  wire logic [wlc_pkg::NUM_WARN-1:0]  warn_mask,            // 1 disables detection
  input  wire logic [1:0]                    warning_latch_setup,  // Bit0 ext, bit1 general
  input  wire logic                          alarm_clear,          // Alarm clear request pulse
  input  wire logic                          enc_batt_latched,     // Encoder battery latch (pin)
  input  wire logic [wlc_pkg::SEL_W-1:0]     warn_sel_one,         // Selection for pin one
  input  wire logic [wlc_pkg::SEL_W-1:0]     warn_sel_two,         // Selection for pin two
  input  wire logic                          comm_hw_fault_a,      // Network peripheral fault A
  input  wire logic                          comm_hw_fault_b,      // Network peripheral fault B
  input  wire logic                          cur_det_fault,        // Current detector abnormal
  input  wire logic                          ctrl_malfunction,     // Control circuit malfunction
  input  wire logic                          self_diag_fail,       // Unspecified self-check fail
  output logic [wlc_pkg::NUM_WARN-1:0]       warn_active,          // Warning state per source
  output logic                               warning_output_one,   // Selected warning pin one
  output logic                               warning_output_two,   // Selected warning pin two
  output logic                               alarm_valid,          // Hardware alarm held
  output logic [7:0]                         alarm_main,           // Alarm main code
  output logic [3:0]                         alarm_sub             // Alarm sub code
);

  // ****************************************************************
  // Encoder latch input synchroniser
  // ****************************************************************
  logic [2:0] batt_sync_r;
  logic [2:0] batt_sync_nxt;
  logic       batt_enc_r;
  logic       batt_enc_nxt;

  // Three stages; level accepted once stages two and three agree
  always_comb begin
    batt_sync_nxt = {batt_sync_r[1:0], enc_batt_latched};
    batt_enc_nxt  = (batt_sync_r[2] == batt_sync_r[1]) ? batt_sync_r[2] : batt_enc_r;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      batt_sync_r <= 3'h0;
      batt_enc_r  <= 1'b0;
    end else begin
      batt_sync_r <= batt_sync_nxt;
      batt_enc_r  <= batt_enc_nxt;
    end
  end

  // ****************************************************************
  // Per-warning state machine and release timer
  // ****************************************************************
  wlc_pkg::wlc_state_e state_r   [wlc_pkg::NUM_WARN];
  wlc_pkg::wlc_state_e state_nxt [wlc_pkg::NUM_WARN];
  logic [wlc_pkg::CNT_W-1:0] cnt_r   [wlc_pkg::NUM_WARN];
  logic [wlc_pkg::CNT_W-1:0] cnt_nxt [wlc_pkg::NUM_WARN];

  genvar gi;
  generate
    for (gi = 0; gi < wlc_pkg::NUM_WARN; gi++) begin : g_warn
      logic cause;
      logic latch_en;
      // Masked causes never raise; cause is the early indication ahead of a trip
      assign cause    = warn_cause[gi] & ~warn_mask[gi];
      // Extended warnings use bit 0, general ones bit 1
      assign latch_en = warn_is_extended[gi] ? warning_latch_setup[wlc_pkg::SETUP_EXT_BIT]
                                             : warning_latch_setup[wlc_pkg::SETUP_GEN_BIT];

      // A cause arriving with a clear keeps the warning set: set wins
      always_comb begin
        state_nxt[gi] = state_r[gi];
        cnt_nxt[gi]   = cnt_r[gi];
        if (gi == wlc_pkg::BATT_IDX) begin
          // Battery ignores local setup; it follows the encoder's own latch
          if (cause || batt_enc_r) begin
            state_nxt[gi] = wlc_pkg::WLC_ACTIVE;
          end else begin
            state_nxt[gi] = wlc_pkg::WLC_IDLE;
          end
          cnt_nxt[gi] = '0;
        end else begin
          case (state_r[gi])
            wlc_pkg::WLC_IDLE: begin
              cnt_nxt[gi] = '0;
              if (cause) begin
                state_nxt[gi] = wlc_pkg::WLC_ACTIVE;
              end
            end
            wlc_pkg::WLC_ACTIVE: begin
              cnt_nxt[gi] = '0;
              if (!cause) begin
                state_nxt[gi] = wlc_pkg::WLC_HOLD;
              end
            end
            default: begin
              if (cause) begin
                // Cause came back: restart the delay
                state_nxt[gi] = wlc_pkg::WLC_ACTIVE;
                cnt_nxt[gi]   = '0;
              end else if (latch_en) begin
                // Held until the alarm clear procedure
                cnt_nxt[gi] = '0;
                if (alarm_clear) begin
                  state_nxt[gi] = wlc_pkg::WLC_IDLE;
                end
              end else if (cnt_r[gi] >= wlc_pkg::CNT_W'(CLEAR_CYCLES - 1)) begin
                state_nxt[gi] = wlc_pkg::WLC_IDLE;
                cnt_nxt[gi]   = '0;
              end else begin
                cnt_nxt[gi] = cnt_r[gi] + wlc_pkg::CNT_W'(1);
              end
            end
          endcase
        end
      end

      always_ff @(posedge clk) begin
        if (!reset_n) begin
          state_r[gi] <= wlc_pkg::WLC_IDLE;
          cnt_r[gi]   <= '0;
        end else begin
          state_r[gi] <= state_nxt[gi];
          cnt_r[gi]   <= cnt_nxt[gi];
        end
      end

      assign warn_active[gi] = (state_r[gi] != wlc_pkg::WLC_IDLE);
    end
  endgenerate

  // The battery entry never uses its timer; it drops as soon as the encoder latch
  // and the local cause are both gone, so the one-second hold does not apply to it

  // ****************************************************************
  // Warning output pins
  // ****************************************************************
  logic out_one_nxt;
  logic out_two_nxt;
  logic out_one_r;
  logic out_two_r;

  // Value 0 is the OR of all; 1..N picks one source; beyond N reads low
  function automatic logic pick(input logic [wlc_pkg::SEL_W-1:0] sel,
                                input logic [wlc_pkg::NUM_WARN-1:0] act);
    logic r;
    r = 1'b0;
    if (sel == '0) begin
      r = |act;
    end else if (int'(sel) <= wlc_pkg::NUM_WARN) begin
      r = act[int'(sel) - 1];
    end
    return r;
  endfunction

  always_comb begin
    out_one_nxt = pick(warn_sel_one, warn_active);
    out_two_nxt = pick(warn_sel_two, warn_active);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_one_r <= 1'b0;
      out_two_r <= 1'b0;
    end else begin
      out_one_r <= out_one_nxt;
      out_two_r <= out_two_nxt;
    end
  end

  assign warning_output_one = out_one_r;
  assign warning_output_two = out_two_r;

  // ****************************************************************
  // Hardware fault alarms
  // ****************************************************************
  logic       alm_v_r;
  logic       alm_v_nxt;
  logic [7:0] alm_main_r;
  logic [7:0] alm_main_nxt;
  logic [3:0] alm_sub_r;
  logic [3:0] alm_sub_nxt;

  // First alarm is kept; these faults need a power cycle, so clear is not honoured
  always_comb begin
    alm_v_nxt    = alm_v_r;
    alm_main_nxt = alm_main_r;
    alm_sub_nxt  = alm_sub_r;
    if (!alm_v_r) begin
      if (comm_hw_fault_a) begin
        alm_v_nxt    = 1'b1;
        alm_main_nxt = wlc_pkg::ALM_MAIN_COMM;
        alm_sub_nxt  = wlc_pkg::ALM_SUB_COMM2;
      end else if (comm_hw_fault_b) begin
        alm_v_nxt    = 1'b1;
        alm_main_nxt = wlc_pkg::ALM_MAIN_COMM;
        alm_sub_nxt  = wlc_pkg::ALM_SUB_COMM3;
      end else if (cur_det_fault) begin
        alm_v_nxt    = 1'b1;
        alm_main_nxt = wlc_pkg::ALM_MAIN_COMM;
        alm_sub_nxt  = wlc_pkg::ALM_SUB_DIAG;
      end else if (ctrl_malfunction || self_diag_fail) begin
        alm_v_nxt    = 1'b1;
        alm_main_nxt = wlc_pkg::ALM_MAIN_OTHER;
        alm_sub_nxt  = wlc_pkg::ALM_SUB_OTHER;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      alm_v_r    <= 1'b0;
      alm_main_r <= 8'h00;
      alm_sub_r  <= 4'h0;
    end else begin
      alm_v_r    <= alm_v_nxt;
      alm_main_r <= alm_main_nxt;
      alm_sub_r  <= alm_sub_nxt;
    end
  end

  assign alarm_valid = alm_v_r;
  assign alarm_main  = alm_main_r;
  assign alarm_sub   = alm_sub_r;

endmodule // wlc_warning_latch

// [wlc_pkg.sv]
// Constants and types for the warning latch and clear block.
// Assumes one 125 MHz control clock; all users reference names as wlc_pkg::name.
package wlc_pkg;

  // ****************************************************************
  // Sizes and fields
  // ****************************************************************
  localparam int          NUM_WARN       = 8;              // Warning sources, index 0 is battery
  localparam int          BATT_IDX       = 0;
  localparam int          SEL_W          = 6;              // Selection value 0..40
  localparam int          SETUP_EXT_BIT  = 0;
  localparam int          SETUP_GEN_BIT  = 1;
  localparam logic [1:0]  SETUP_RESET    = 2'h0;
  localparam logic [7:0]  ALM_MAIN_COMM  = 8'h62;          // Main code 98
  localparam logic [3:0]  ALM_SUB_COMM2  = 4'h2;
  localparam logic [3:0]  ALM_SUB_COMM3  = 4'h3;
  localparam logic [3:0]  ALM_SUB_DIAG   = 4'h5;
  localparam logic [7:0]  ALM_MAIN_OTHER = 8'hFF;          // Generic other-error code
  localparam logic [3:0]  ALM_SUB_OTHER  = 4'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_HZ         = 125_000_000;
  localparam int          CLEAR_DELAY_MS = 1000;           // One second
  localparam int          CLEAR_CYCLES   = CLK_HZ / 1000 * CLEAR_DELAY_MS;
  localparam int          CNT_W          = 27;

  typedef enum logic [1:0] {WLC_IDLE, WLC_ACTIVE, WLC_HOLD} wlc_state_e;

endpackage : wlc_pkg

// [wlc_enc_model.sv]
// Behavioural encoder battery latch for the warning latch bench.
// Assumes the bench drives its requests at the falling clock edge.
`timescale 1ns/1ps
module wlc_enc_model (
  input  wire logic clk,                 // Control clock
  input  wire logic batt_low,            // Battery low seen by encoder
  input  wire logic unlatch,             // Encoder unlatch command
  output logic      batt_latch_r         // Latched battery flag (level)
);
  // Encoder starts with its latch released
  initial batt_latch_r = 1'b0;
  // Latch holds until the encoder itself is told to let go
  always @(posedge clk) begin
    if (batt_low) begin
      batt_latch_r <= 1'b1;
    end else if (unlatch) begin
      batt_latch_r <= 1'b0;
    end
  end
endmodule // wlc_enc_model

// [wlc_warning_latch_monitor.sv]
// Checker on the top ports of the warning latch block; source 1 is general.
// Assumes setup and mask stay steady while a warning is held.
`timescale 1ns/1ps
module wlc_warning_latch_monitor #(
  parameter int unsigned CLEAR_CYCLES = 20  // Release delay in cycles
) (
  input wire logic       clk,                  // Control clock
  input wire logic       reset_n,              // Sync reset, active low
  input wire logic [7:0] warn_cause,           // Raw causes
  input wire logic [7:0] warn_mask,            // Detection mask
  input wire logic [7:0] warn_is_extended,     // Extended marks
  input wire logic [1:0] warning_latch_setup,  // Latch setup
  input wire logic       alarm_clear,          // Clear request
  input wire logic       enc_batt_latched,     // Encoder latch
  input wire logic [5:0] warn_sel_one,         // Pin one select
  input wire logic [7:0] warn_active,          // Warning state
  input wire logic       warning_output_one,   // Pin one
  input wire logic       alarm_valid,          // Alarm held
  input wire logic       comm_hw_fault_a,      // Fault A
  input wire logic       comm_hw_fault_b,      // Fault B
  input wire logic       cur_det_fault,        // Current detector
  input wire logic [7:0] alarm_main,           // Main code
  input wire logic [3:0] alarm_sub             // Sub code
);
  // ****************************************************************
  // Helpers: cycles since source 1 cause was last seen
  // ****************************************************************
  logic [7:0] low_cnt_r, low_cnt_nxt;
  wire logic [6:0] live = warn_cause[7:1] & ~warn_mask[7:1];
  wire logic       any_warn = |warn_active;
  wire logic       lat_gen = warning_latch_setup[1] & ~warn_is_extended[1];
  // Saturates so a long idle never wraps into a false antecedent
  always_comb low_cnt_nxt = warn_cause[1] ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
  always_ff @(posedge clk) low_cnt_r <= reset_n ? low_cnt_nxt : 8'h00;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_warn_raise: assert property (
    live != 7'h00 |=> (warn_active[7:1] & $past(live)) == $past(live)) else $error("warning not raised");
  chk_nonlatch_release: assert property (
    !lat_gen && low_cnt_r == CLEAR_CYCLES + 1 |-> !warn_active[1]) else $error("warning not released");
  chk_hold_restart: assert property (
    $fell(warn_active[1]) && !lat_gen |-> low_cnt_r == CLEAR_CYCLES + 1) else $error("warning released early");
  chk_latch_keep: assert property (
    warn_active[1] && lat_gen && !alarm_clear && !$past(alarm_clear) |=> warn_active[1])
    else $error("latched warning lost");
  chk_latch_clear: assert property (
    alarm_clear && warn_active[1] && lat_gen && !warn_cause[1] && !$past(warn_cause[1]) |-> ##[1:2] !warn_active[1])
    else $error("latched warning not cleared");
  chk_batt_release: assert property (
    $fell(warn_active[0]) |-> !$past(enc_batt_latched, 2)) else $error("battery warning dropped early");
  chk_pin_or: assert property (
    warn_sel_one == 6'h00 |=> warning_output_one == $past(any_warn)) else $error("pin one not OR of warnings");
  chk_alarm_code: assert property (
    $rose(alarm_valid) |-> {alarm_main, alarm_sub} == ($past(comm_hw_fault_a) ? 12'h622 :
    $past(comm_hw_fault_b) ? 12'h623 : $past(cur_det_fault) ? 12'h625 : 12'hFF0)) else $error("wrong alarm code");
  chk_alarm_sticky: assert property (
    alarm_valid |=> alarm_valid && $stable(alarm_main) && $stable(alarm_sub)) else $error("alarm not held");
endmodule // wlc_warning_latch_monitor

// [wlc_warning_latch_tb.sv]
// Self-checking bench for the warning latch block with an encoder model.
// Assumes a short release delay parameter; inputs change at falling edges.
`timescale 1ns/1ps
module wlc_warning_latch_tb;
  localparam int unsigned CLR = 20;  // Shortened one-second delay
  logic       clk = 1'b0, reset_n = 1'b0, alarm_clear = 1'b0, batt_low = 1'b0, unlatch = 1'b0, enc_latch;
  logic [7:0] warn_cause = 8'h00, mask = 8'h00, warn_active, alarm_main;
  logic [1:0] setup = 2'h0;
  logic [4:0] faults = 5'h00;
  logic [3:0] alarm_sub;
  logic       pin_one, pin_two, alarm_valid;
  int         error_cnt = 0, tests_run = 0, cycles = 0;
  always #4 clk = ~clk;
  wlc_enc_model enc (.clk(clk), .batt_low(batt_low), .unlatch(unlatch), .batt_latch_r(enc_latch));
  wlc_warning_latch #(.CLEAR_CYCLES(CLR)) dut (.clk(clk), .reset_n(reset_n), .warn_cause(warn_cause),
    .warn_is_extended(8'h04), .warn_mask(mask), .warning_latch_setup(setup), .alarm_clear(alarm_clear),
    .enc_batt_latched(enc_latch), .warn_sel_one(6'h00), .warn_sel_two(6'h02), .comm_hw_fault_a(faults[4]),
    .comm_hw_fault_b(faults[3]), .cur_det_fault(faults[2]), .ctrl_malfunction(faults[1]),
    .self_diag_fail(faults[0]), .warn_active(warn_active), .warning_output_one(pin_one),
    .warning_output_two(pin_two), .alarm_valid(alarm_valid), .alarm_main(alarm_main), .alarm_sub(alarm_sub));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse_clear();
    alarm_clear = 1'b1;
    tick(1);
    alarm_clear = 1'b0;
    tick(2);
  endtask
  task automatic do_reset();
    faults = 5'h00;
    reset_n = 1'b0;
    tick(5);
    reset_n = 1'b1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Cause returns mid-hold, so a missing restart shows as an early release
  task automatic t_nonlatch();
    do_reset();
    warn_cause = 8'h02;
    tick(1);
    check("raise", warn_active, 8'h02);
    warn_cause = 8'h00;
    tick(1);
    check("pin one", pin_one, 1'b1);
    check("pin two", pin_two, 1'b1);
    tick(CLR - 4);
    check("hold", warn_active, 8'h02);
    warn_cause = 8'h02;
    tick(1);
    warn_cause = 8'h00;
    tick(CLR);
    check("restart", warn_active, 8'h02);
    tick(1);
    check("release", warn_active, 8'h00);
    // Masked cause must never raise its warning
    mask = 8'h02;
    warn_cause = 8'h02;
    tick(2);
    check("masked", warn_active, 8'h00);
    warn_cause = 8'h00;
    mask = 8'h00;
  endtask
  // Each setup bit latches only its own class of warning
  task automatic t_latch();
    for (int i = 1; i < 3; i++) begin
      do_reset();
      setup = i[1:0];
      warn_cause = 8'h06;
      tick(1);
      warn_cause = 8'h00;
      tick(CLR + 6);
      check("latched", warn_active, (i == 1) ? 8'h04 : 8'h02);
      check("pin two sel", pin_two, (i == 1) ? 1'b0 : 1'b1);
      pulse_clear();
      check("cleared", warn_active, 8'h00);
    end
    setup = 2'h0;
  endtask
  // Alarm clear and a non-latching setup must not drop the battery warning
  task automatic t_batt();
    do_reset();
    batt_low = 1'b1;
    tick(1);
    batt_low = 1'b0;
    tick(CLR + 6);
    pulse_clear();
    check("batt held", warn_active, 8'h01);
    unlatch = 1'b1;
    tick(1);
    unlatch = 1'b0;
    tick(6);
    check("batt freed", warn_active, 8'h00);
  endtask
  // Later faults must not overwrite the first held code
  task automatic t_alarm();
    logic [4:0]  fv [5] = '{5'h10, 5'h0C, 5'h04, 5'h02, 5'h01};
    logic [11:0] cv [5] = '{12'h622, 12'h623, 12'h625, 12'hFF0, 12'hFF0};
    for (int i = 0; i < 5; i++) begin
      do_reset();
      faults = fv[i];
      tick(2);
      faults = 5'h1F;
      tick(2);
      check("alarm code", {alarm_main, alarm_sub}, cv[i]);
      check("alarm valid", alarm_valid, 1'b1);
    end
  endtask
  initial begin
    t_nonlatch();
    t_latch();
    t_batt();
    t_alarm();
    stop_test();
  end
  // Hang guard: the full run needs well under 500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
endmodule // wlc_warning_latch_tb
bind wlc_warning_latch wlc_warning_latch_monitor #(.CLEAR_CYCLES(CLEAR_CYCLES)) u_mon (.clk, .reset_n,
  .warn_cause, .warn_mask, .warn_is_extended, .warning_latch_setup, .alarm_clear, .enc_batt_latched,
  .warn_sel_one, .warn_active, .warning_output_one, .alarm_valid, .comm_hw_fault_a, .comm_hw_fault_b,
  .cur_det_fault, .alarm_main, .alarm_sub);
